// *** dv/lsd_latch_model.sv ***
// Decoder drivers with per-place latches behind the scanner pins
`timescale 1ns/10ps
`default_nettype none
module lsd_latch_model
(
   // Clock and wiring options
   input wire logic mclk,
   input wire logic [2:0] modeIn,
   input wire logic wipe,
   // Open-collector drive from the scanner
   input wire logic [lsd_pkg::LSD_OUT_W-1:0] yDrvLow,
   // Digits held by each display
   output logic [15:0] shown1,
   output logic [15:0] shown2
);
   import lsd_pkg::*;
   logic [11:0] pinLevel;
   logic [3:0] latchEn;
   logic [3:0] dataMask;
   assign pinLevel = ~yDrvLow;
   assign dataMask = {4{modeIn[LSD_MODE_DATA_NEG_BIT]}};
   assign latchEn = ~pinLevel[7:4] ^ {4{modeIn[LSD_MODE_LATCH_NEG_BIT]}};
   always @(posedge mclk)
   begin
      if (wipe)
      begin
         shown1 <= 16'hFFFF;
         shown2 <= 16'hFFFF;
      end
      else
      begin
         for (int p = 0; p < 4; p++)
         begin
            if (latchEn[p])
            begin
               shown1[p*4 +: 4] <= ~pinLevel[3:0] ^ dataMask;
               shown2[p*4 +: 4] <= ~pinLevel[11:8] ^ dataMask;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/lsd_scanner_checker.sv ***
// Concurrent checks on the scanner top-level ports
`timescale 1ns/10ps
`default_nettype none
module lsd_scanner_checker
(
   // Clock, reset, scan
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scanTick,
   // Bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   // Display side and status
   input wire logic [lsd_pkg::LSD_OUT_W-1:0] yDrvLow,
   input wire logic passDoneFlag,
   input wire logic irq
);
   import lsd_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence s_wtake;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_wanswer;
      !awready && !wready ##1 bvalid;
   endsequence
   sequence s_rtake;
      arvalid && arready;
   endsequence
   a_write_answer:
      assert property (s_wtake |=> s_wanswer)
      else $error("write response not two cycles after take");
   a_read_answer:
      assert property (s_rtake |=> rvalid && !arready)
      else $error("read data not one cycle after take");
   a_write_busy:
      assert property (bvalid |-> !awready && !wready)
      else $error("write channels ready while response pending");
   a_read_busy:
      assert property (rvalid |-> !arready)
      else $error("read address ready while data pending");
   a_strobe_single:
      assert property ($onehot0(yDrvLow[7:4]) || $onehot0(~yDrvLow[7:4]))
      else $error("more than one latch strobe active");
   a_done_clears:
      assert property (passDoneFlag && scanTick && ce |=> !passDoneFlag)
      else $error("done flag outlived one scan");
   a_done_follows:
      assert property ($rose(passDoneFlag) |-> $past(scanTick))
      else $error("done flag rose without a scan tick");
   a_reset_quiet:
      assert property ($fell(rst) |-> yDrvLow == 12'h000 && !passDoneFlag
                       && !irq)
      else $error("outputs active out of reset");
endmodule
`default_nettype wire

// *** dv/test_latched_seven_segment_scanner.sv ***
// Self-checking bench for the latched seven-segment scanner
`timescale 1ns/10ps
`default_nettype none
module test_latched_seven_segment_scanner;
   import lsd_pkg::*;
   localparam logic [15:0] VAL0_BCD = 16'h1234;
   localparam logic [15:0] VAL1_BCD = 16'h9999;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic scanTick = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic bready = 1'b1;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, passDoneFlag, irq;
   logic [1:0] bresp, rresp, rdResp;
   logic [31:0] rdata, rdVal;
   logic [11:0] yDrvLow;
   logic [2:0] modeIn = 3'h0;
   logic wipe = 1'b0;
   logic [15:0] shown1, shown2;
   int mismatches = 0;
   int nCompared = 0;
   always #20 mclk = ~mclk;
   lsd_scanner DUT (.mclk(mclk), .rst(rst), .ce(ce), .scanTick(scanTick),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .yDrvLow(yDrvLow), .passDoneFlag(passDoneFlag),
      .irq(irq));
   lsd_latch_model partner (.mclk(mclk), .modeIn(modeIn), .wipe(wipe),
      .yDrvLow(yDrvLow), .shown1(shown1), .shown2(shown2));
   // ---------------------------------------------------------------
   // Bus and check helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] seen);
      nCompared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge mclk); while (!bvalid);
      rdResp = bresp;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge mclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge mclk); while (!rvalid);
      rdVal = rdata;
      rdResp = rresp;
   endtask
   task automatic tick();
      scanTick <= 1'b1;
      @(posedge mclk);
      scanTick <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic start(input logic [2:0] m);
      axi_wr(LSD_OFF_CTRL, 32'h0000_0000);
      axi_wr(LSD_OFF_MODE, {29'h0, m});
      modeIn <= m;
      wipe <= 1'b1;
      axi_wr(LSD_OFF_CTRL, 32'h0000_0001);
      wipe <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic reg_reset();
      logic [7:0] offs [5];
      offs = '{LSD_OFF_CTRL, LSD_OFF_MODE, LSD_OFF_VAL0, LSD_OFF_VAL1,
               LSD_OFF_IRQ_EN};
      foreach (offs[k])
      begin
         axi_rd(offs[k]);
         check("reset value", 16'h0000, rdVal[15:0]);
         check("read resp", 16'(LSD_RESP_OKAY), 16'(rdResp));
      end
      axi_rd(8'h24);
      check("unmapped resp", 16'(LSD_RESP_SLVERR), 16'(rdResp));
      check("unmapped data", 16'h0000, rdVal[15:0]);
      axi_wr(8'h24, 32'h0000_FFFF);
      check("unmapped write", 16'(LSD_RESP_SLVERR), 16'(rdResp));
      axi_rd(LSD_OFF_SEQ);
      check("seq word", 16'h0031, rdVal[15:0]);
   endtask
   task automatic run_pass(input logic [2:0] m, input logic ok);
      logic [3:0] strobe;
      logic [3:0] dMask;
      logic [3:0] dig2;
      int j;
      int place;
      dMask = {4{m[LSD_MODE_DATA_NEG_BIT]}};
      for (int i = 0; i <= 12; i++)
      begin
         if (i > 0) tick();
         j = i % 12;
         place = 3 - j / 3;
         strobe = (ok && j % 3 == 1) ? 4'h1 << place : 4'h0;
         strobe = strobe ^ {4{m[LSD_MODE_LATCH_NEG_BIT]}};
         check("strobes", 16'(strobe), 16'(yDrvLow[7:4]));
         if (ok && j % 3 == 1)
         begin
            dig2 = m[LSD_MODE_TWO_BIT] ? VAL1_BCD[place*4+:4] ^ dMask : 4'h0;
            check("digit one", 16'(VAL0_BCD[place*4 +: 4] ^ dMask),
                  16'(yDrvLow[3:0]));
            check("digit two", 16'(dig2), 16'(yDrvLow[11:8]));
         end
         check("done flag", 16'(ok && i == 12), 16'(passDoneFlag));
      end
      tick();
      check("done flag", 16'h0000, 16'(passDoneFlag));
      if (ok)
      begin
         check("display one", VAL0_BCD, shown1);
         if (m[LSD_MODE_TWO_BIT])
            check("display two", VAL1_BCD, shown2);
      end
   endtask
   task automatic irq_path();
      axi_rd(LSD_OFF_IRQ_STAT);
      check("irq status", 16'h0001, rdVal[15:0]);
      check("irq", 16'h0001, 16'(irq));
      axi_wr(LSD_OFF_IRQ_EN, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      check("irq masked", 16'h0000, 16'(irq));
      axi_wr(LSD_OFF_IRQ_EN, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      check("irq unmasked", 16'h0001, 16'(irq));
      axi_wr(LSD_OFF_IRQ_CLR, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      check("irq cleared", 16'h0000, 16'(irq));
      axi_rd(LSD_OFF_IRQ_STAT);
      check("irq status", 16'h0000, rdVal[15:0]);
   endtask
   task automatic restart_mid();
      start(3'h0);
      repeat (4) tick();
      ce <= 1'b0;
      tick();
      ce <= 1'b1;
      check("frozen strobe", 16'h0004, 16'(yDrvLow[7:4]));
      axi_wr(LSD_OFF_CTRL, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      check("outputs off", 16'h0000, 16'(yDrvLow));
      axi_wr(LSD_OFF_CTRL, 32'h0000_0001);
      repeat (3) @(posedge mclk);
      run_pass(3'h0, 1'b1);
   endtask
   task automatic error_pass();
      axi_wr(LSD_OFF_IRQ_EN, 32'h0000_0003);
      axi_wr(LSD_OFF_IRQ_CLR, 32'h0000_0003);
      axi_wr(LSD_OFF_VAL0, 32'h0000_2710);
      start(3'h0);
      run_pass(3'h0, 1'b0);
      axi_rd(LSD_OFF_IRQ_STAT);
      check("error status", 16'h0002, rdVal[15:0]);
      check("error irq", 16'h0001, 16'(irq));
   endtask
   // ---------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("compared %0d mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      reg_reset();
      axi_wr(LSD_OFF_VAL0, 32'h0000_04D2);
      axi_wr(LSD_OFF_VAL1, 32'h0000_270F);
      axi_wr(LSD_OFF_IRQ_EN, 32'h0000_0001);
      for (int m = 0; m < 8; m++)
      begin
         start(3'(m));
         run_pass(3'(m), 1'b1);
      end
      irq_path();
      restart_mid();
      error_pass();
      complete_run();
   end
   // About thirty times the expected run length
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      complete_run();
   end
endmodule
bind lsd_scanner lsd_scanner_checker u_chk (.mclk(mclk), .rst(rst),
   .ce(ce), .scanTick(scanTick), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .yDrvLow(yDrvLow),
   .passDoneFlag(passDoneFlag), .irq(irq));
`default_nettype wire

// *** rtl/lsd_bcd_conv.sv ***
// Binary to four-digit packed decimal converter
`timescale 1ns/10ps
`default_nettype none
module lsd_bcd_conv
(
   // Binary source word
   input wire logic [15:0] binVal,
   // Four decimal digits, thousands in the top nibble
   output logic [15:0] bcdVal
);
   import lsd_pkg::*;

   // Shift-and-add-three, one pass per source bit
   always_comb
   begin
      logic [31:0] sh;
      sh = {16'h0000, binVal};
      for (int i = 0; i < 16; i++)
      begin
         for (int d = 0; d < 4; d++)
         begin
            if (sh[16 + 4 * d +: 4] > 4'h4)
            begin
               sh[16 + 4 * d +: 4] = sh[16 + 4 * d +: 4] + 4'h3;
            end
         end
         sh = {sh[30:0], 1'b0};
      end
      bcdVal = sh[31:16];
   end
endmodule
`default_nettype wire

// *** rtl/lsd_scanner.sv ***
// Latched seven-segment scanner with AXI4-Lite registers
// What this block does
// - Eight outputs serve one display, twelve serve two displays.
// - The first value word goes to display one, the next to display two.
// - Modes 0 to 3 run one display on eight outputs.
// - Modes 4 to 7 add a second data nibble and share the four strobes.
// - Mode picks data and strobe polarity apart; negative data inverts.
// - Each value becomes four decimal digits weighted 8, 4, 2 and 1.
// - A displayed value above 9999 raises an operation error, not a display update.
// - Outputs 0..3 carry display one digits, outputs 4..7 the strobes.
// - With two displays, outputs 8..11 carry display two digits.
// - Strobes cycle while enabled; an enable rise restarts the cycle.
// - A full pass over the strobes takes twelve scan cycles.
// - At the end of an error-free pass the done flag stands for one scan cycle.
// - An asserted output pulls its open-collector pin low.
`timescale 1ns/10ps
`default_nettype none
module lsd_scanner
(
   // Clock, reset, clock enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Controller scan cycle pulse
   input wire logic scanTick,
   // AXI4-Lite write address
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Open-collector output enables, high pulls the pin low
   output logic [lsd_pkg::LSD_OUT_W-1:0] yDrvLow,
   // Status
   output logic passDoneFlag,
   output logic irq
);
   import lsd_pkg::*;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic [31:0] wmask(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8 * b +: 8] = dat[8 * b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [3:0] digitSel(input logic [15:0] bcd,
                                           input logic [1:0] place);
      return bcd[{place, 2'b00} +: 4];
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic awHeld_r;
   logic wHeld_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic ctrlEn_r;
   logic [2:0] mode_r;
   logic [15:0] val0_r;
   logic [15:0] val1_r;
   logic [1:0] irqStat_r;
   logic [1:0] irqEn_r;
   logic irq_r;
   logic enPrev_r;
   lsd_state_t state_r;
   lsd_state_t state_nxt;
   logic [1:0] place_r;
   logic [1:0] place_nxt;
   logic [15:0] word0_r;
   logic [15:0] word1_r;
   logic passOk_r;
   logic passDone_r;
   logic passDone_nxt;
   logic [LSD_OUT_W-1:0] yDrvLow_r;
   logic [LSD_OUT_W-1:0] y_nxt;
   logic [15:0] bcd0;
   logic [15:0] bcd1;
   logic [31:0] wFull;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire logic awTake = awvalid & awready_r;
   wire logic wTake = wvalid & wready_r;
   wire logic doWrite = awHeld_r & wHeld_r & ~bvalid_r;
   wire logic arTake = arvalid & arready_r;
   wire logic wrCtrl = doWrite & (awAddr_r == LSD_OFF_CTRL);
   wire logic wrMode = doWrite & (awAddr_r == LSD_OFF_MODE);
   wire logic wrVal0 = doWrite & (awAddr_r == LSD_OFF_VAL0);
   wire logic wrVal1 = doWrite & (awAddr_r == LSD_OFF_VAL1);
   wire logic wrClr = doWrite & (awAddr_r == LSD_OFF_IRQ_CLR);
   wire logic wrIrqEn = doWrite & (awAddr_r == LSD_OFF_IRQ_EN);
   wire logic wrHit = wrCtrl | wrMode | wrVal0 | wrVal1 | wrClr | wrIrqEn;
   wire logic rdHit = (araddr == LSD_OFF_CTRL) | (araddr == LSD_OFF_MODE)
      | (araddr == LSD_OFF_VAL0) | (araddr == LSD_OFF_VAL1)
      | (araddr == LSD_OFF_STAT) | (araddr == LSD_OFF_IRQ_STAT)
      | (araddr == LSD_OFF_IRQ_CLR) | (araddr == LSD_OFF_IRQ_EN)
      | (araddr == LSD_OFF_SEQ);
   assign wFull = wmask(32'h0000_0000, wData_r, wStrb_r);
   wire logic [31:0] val0Mrg = wmask({16'h0000, val0_r}, wData_r, wStrb_r);
   wire logic [31:0] val1Mrg = wmask({16'h0000, val1_r}, wData_r, wStrb_r);

   // ---------------------------------------------------------------
   // Sequencer decode
   // ---------------------------------------------------------------
   // mode field is three bits wide
   wire logic twoDisp = mode_r[LSD_MODE_TWO_BIT];
   wire logic dataNeg = mode_r[LSD_MODE_DATA_NEG_BIT];
   wire logic latchNeg = mode_r[LSD_MODE_LATCH_NEG_BIT];
   wire logic tick = scanTick;
   wire logic enRise = ctrlEn_r & ~enPrev_r;
   wire logic lastStep = tick & (state_r == LSD_HOLD)
      & (place_r == LSD_LOW_PLACE);
   wire logic startPass = ctrlEn_r & (enRise | lastStep);
   // range check of the source words
   wire logic bad0 = val0_r > LSD_MAX_VALUE;
   wire logic bad1 = twoDisp & (val1_r > LSD_MAX_VALUE);
   wire logic errEv = startPass & (bad0 | bad1);
   wire logic doneEv = lastStep & passOk_r & ~enRise;
   wire logic running = ctrlEn_r & (state_r != LSD_IDLE);
   wire logic [1:0] irqEv = {errEv, doneEv};
   wire logic [1:0] irqClr = wrClr ? wFull[1:0] : 2'b00;
   // first word to display one, next word to display two
   wire logic [3:0] dig0 = digitSel(word0_r, place_r);
   wire logic [3:0] dig1 = digitSel(word1_r, place_r);
   wire logic [3:0] dat0 = dataNeg ? ~dig0 : dig0;
   wire logic [3:0] dat1 = dataNeg ? ~dig1 : dig1;
   wire logic strobeAct = (state_r == LSD_STROBE) & passOk_r;
   wire logic [3:0] strobeHot = strobeAct ? (4'h1 << place_r) : 4'h0;
   wire logic [3:0] latchLines = latchNeg ? ~strobeHot : strobeHot;

   // ---------------------------------------------------------------
   // Converters
   // ---------------------------------------------------------------
   // binary to 8-4-2-1 digits
   lsd_bcd_conv uConv0
   (
      .binVal(val0_r),
      .bcdVal(bcd0)
   );

   lsd_bcd_conv uConv1
   (
      .binVal(val1_r),
      .bcdVal(bcd1)
   );

   // ---------------------------------------------------------------
   // Sequencer next state
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      place_nxt = place_r;
      if (!ctrlEn_r)
      begin
         state_nxt = LSD_IDLE;
         place_nxt = LSD_TOP_PLACE;
      end
      // restart from the top on enable rise
      else if (startPass)
      begin
         state_nxt = LSD_DATA;
         place_nxt = LSD_TOP_PLACE;
      end
      else if (tick)
      begin
         // three scans per place, four places
         // data, strobe, hold, then next lower place
         case (state_r)
            LSD_DATA:
            begin
               state_nxt = LSD_STROBE;
            end
            LSD_STROBE:
            begin
               state_nxt = LSD_HOLD;
            end
            LSD_HOLD:
            begin
               state_nxt = LSD_DATA;
               place_nxt = place_r - 2'h1;
            end
            default:
            begin
               state_nxt = LSD_IDLE;
            end
         endcase
      end
   end

   // flag stands from pass end to the next scan
   assign passDone_nxt = doneEv ? 1'b1 : (tick ? 1'b0 : passDone_r);

   // ---------------------------------------------------------------
   // Output mapping
   // ---------------------------------------------------------------
   always_comb
   begin
      y_nxt = '0;
      if (running)
      begin
         // digits on 0..3, strobes on 4..7
         y_nxt[LSD_DATA0_LSB +: 4] = dat0;
         y_nxt[LSD_LATCH_LSB +: 4] = latchLines;
         // second digit group only in two-display modes
         if (twoDisp)
         begin
            y_nxt[LSD_DATA1_LSB +: 4] = dat1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= LSD_RESP_OKAY;
      end
      else if (ce)
      begin
         if (awTake)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
         end
         if (wTake)
         begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         awready_r <= ~awHeld_r & ~awTake & ~doWrite & ~bvalid_r;
         wready_r <= ~wHeld_r & ~wTake & ~doWrite & ~bvalid_r;
         if (doWrite)
         begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wrHit ? LSD_RESP_OKAY : LSD_RESP_SLVERR;
         end
         else if (bvalid_r & bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= LSD_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end
      else if (ce)
      begin
         arready_r <= ~arTake & ~rvalid_r;
         if (arTake)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= rdHit ? LSD_RESP_OKAY : LSD_RESP_SLVERR;
            case (araddr)
               LSD_OFF_CTRL: rdata_r <= {31'h0, ctrlEn_r};
               LSD_OFF_MODE: rdata_r <= {29'h0, mode_r};
               LSD_OFF_VAL0: rdata_r <= {16'h0000, val0_r};
               LSD_OFF_VAL1: rdata_r <= {16'h0000, val1_r};
               LSD_OFF_STAT: rdata_r <= {29'h0, passOk_r, passDone_r,
                                         running};
               LSD_OFF_IRQ_STAT: rdata_r <= {30'h0, irqStat_r};
               LSD_OFF_IRQ_EN: rdata_r <= {30'h0, irqEn_r};
               // state word is read-only to software
               LSD_OFF_SEQ: rdata_r <= {26'h0, place_r, state_r};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
         else if (rvalid_r & rready)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ctrlEn_r <= LSD_CTRL_EN_RST;
         mode_r <= LSD_MODE_RST;
         val0_r <= LSD_VAL_RST;
         val1_r <= LSD_VAL_RST;
         irqEn_r <= LSD_IRQ_EN_RST;
         irqStat_r <= 2'h0;
         irq_r <= 1'b0;
      end
      else if (ce)
      begin
         if (wrCtrl)
         begin
            ctrlEn_r <= wFull[LSD_CTRL_EN_BIT];
         end
         if (wrMode)
         begin
            mode_r <= wFull[2:0];
         end
         if (wrVal0)
         begin
            val0_r <= val0Mrg[15:0];
         end
         if (wrVal1)
         begin
            val1_r <= val1Mrg[15:0];
         end
         if (wrIrqEn)
         begin
            irqEn_r <= wFull[1:0];
         end
         // Set wins over a same-cycle clear
         irqStat_r <= (irqStat_r & ~irqClr) | irqEv;
         irq_r <= |(((irqStat_r & ~irqClr) | irqEv) & irqEn_r);
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         enPrev_r <= 1'b0;
         state_r <= LSD_IDLE;
         place_r <= LSD_TOP_PLACE;
         word0_r <= 16'h0000;
         word1_r <= 16'h0000;
         passOk_r <= 1'b0;
         passDone_r <= 1'b0;
      end
      else if (ce)
      begin
         enPrev_r <= ctrlEn_r;
         state_r <= state_nxt;
         place_r <= place_nxt;
         passDone_r <= passDone_nxt;
         if (startPass)
         begin
            // a bad word blanks the strobes for this pass
            passOk_r <= ~(bad0 | bad1);
            if (!(bad0 | bad1))
            begin
               word0_r <= bcd0;
               word1_r <= bcd1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         yDrvLow_r <= '0;
      end
      else if (ce)
      begin
         // logic one pulls the pin low
         yDrvLow_r <= y_nxt;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign yDrvLow = yDrvLow_r;
   assign passDoneFlag = passDone_r;
   assign irq = irq_r;
endmodule
`default_nettype wire

// *** shared/lsd_pkg.sv ***
// Constants and types for the latched seven-segment scanner
package lsd_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] LSD_OFF_CTRL = 8'h00;
   localparam logic [7:0] LSD_OFF_MODE = 8'h04;
   localparam logic [7:0] LSD_OFF_VAL0 = 8'h08;
   localparam logic [7:0] LSD_OFF_VAL1 = 8'h0C;
   localparam logic [7:0] LSD_OFF_STAT = 8'h10;
   localparam logic [7:0] LSD_OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] LSD_OFF_IRQ_CLR = 8'h18;
   localparam logic [7:0] LSD_OFF_IRQ_EN = 8'h1C;
   localparam logic [7:0] LSD_OFF_SEQ = 8'h20;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int LSD_CTRL_EN_BIT = 0;
   localparam int LSD_MODE_LATCH_NEG_BIT = 0;
   localparam int LSD_MODE_DATA_NEG_BIT = 1;
   localparam int LSD_MODE_TWO_BIT = 2;
   localparam int LSD_IRQ_DONE_BIT = 0;
   localparam int LSD_IRQ_ERR_BIT = 1;
   localparam int LSD_STAT_RUN_BIT = 0;
   localparam int LSD_STAT_DONE_BIT = 1;
   localparam int LSD_STAT_OK_BIT = 2;
   localparam int LSD_DATA0_LSB = 0;
   localparam int LSD_LATCH_LSB = 4;
   localparam int LSD_DATA1_LSB = 8;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic LSD_CTRL_EN_RST = 1'b0;
   localparam logic [2:0] LSD_MODE_RST = 3'h0;
   localparam logic [15:0] LSD_VAL_RST = 16'h0000;
   localparam logic [1:0] LSD_IRQ_EN_RST = 2'h0;
   // ---------------------------------------------------------------
   // Sizes and sequencing counts
   // ---------------------------------------------------------------
   localparam int LSD_OUT_W = 12;
   localparam logic [15:0] LSD_MAX_VALUE = 16'h270F;
   localparam logic [1:0] LSD_TOP_PLACE = 2'h3;
   localparam logic [1:0] LSD_LOW_PLACE = 2'h0;
   // Three scans per place, four places: twelve scans per pass
   localparam int LSD_SCANS_PER_PLACE = 3;
   localparam logic [1:0] LSD_RESP_OKAY = 2'b00;
   localparam logic [1:0] LSD_RESP_SLVERR = 2'b10;
   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [3:0]
   {
      LSD_IDLE = 4'b0001,
      LSD_DATA = 4'b0010,
      LSD_STROBE = 4'b0100,
      LSD_HOLD = 4'b1000
   } lsd_state_t;
endpackage
